// >>> dpp_pkg.sv
// package: constants and types of the dual parallel port block
package dpp_pkg;
	// data width of host bus and peripheral lines
	localparam int unsigned DPP_W          = 8;
	// operating modes held in the two-bit mode field
	localparam logic [1:0]  DPP_MODE_OUT   = 2'h0;
	localparam logic [1:0]  DPP_MODE_IN    = 2'h1;
	localparam logic [1:0]  DPP_MODE_BIDIR = 2'h2;
	localparam logic [1:0]  DPP_MODE_BIT   = 2'h3;
	// control word identification by its low nibble
	localparam logic [3:0]  DPP_CW_MODE    = 4'hF;
	localparam logic [3:0]  DPP_CW_ICW     = 4'h7;
	localparam logic [3:0]  DPP_CW_IEN     = 4'h3;
	// field positions inside control words
	localparam int unsigned DPP_MODE_MSB   = 7;
	localparam int unsigned DPP_MODE_LSB   = 6;
	localparam int unsigned DPP_VEC_BIT    = 0;
	localparam int unsigned DPP_ICW_IE     = 7;
	localparam int unsigned DPP_ICW_AND    = 6;
	localparam int unsigned DPP_ICW_HIGH   = 5;
	localparam int unsigned DPP_ICW_MASKF  = 4;
	// opcode bytes of the two-byte interrupt return
	localparam logic [7:0]  DPP_OP_PREFIX  = 8'hED;
	localparam logic [7:0]  DPP_OP_RETURN  = 8'h4D;
	// reset values of the per-port registers
	localparam logic [1:0]  DPP_MODE_RST   = DPP_MODE_IN;
	localparam logic [7:0]  DPP_DIR_RST    = 8'hFF;
	localparam logic [7:0]  DPP_MASK_RST   = 8'hFF;
	localparam logic [7:0]  DPP_VEC_RST    = 8'h00;
	localparam logic [7:0]  DPP_DATA_RST   = 8'h00;
	// expectation of the next control word for a port
	typedef enum logic [1:0] {
		DPP_CW_IDLE = 2'b00,
		DPP_CW_DIR  = 2'b01,
		DPP_CW_MASK = 2'b11
	} dpp_cw_state_t;
endpackage : dpp_pkg

// >>> dpp_fetch_if.sv
// interface: opcode fetch stream between bus logic and return decoder
`timescale 1ns/1ps
interface dpp_fetch_if;
	logic       fetch_act; // opcode fetch in progress
	logic [7:0] op_byte;   // sampled host data during fetch
	logic       ed_seen;   // prefix byte decoded, until next fetch
	logic       return_from_irq_opcode;      // one-cycle pulse on return opcode
	modport dec (input fetch_act, input op_byte,
		output ed_seen, output return_from_irq_opcode);
	modport ctl (output fetch_act, output op_byte,
		input ed_seen, input return_from_irq_opcode);
endinterface : dpp_fetch_if

// >>> dpp_return_from_irq_opcode_dec.sv
// module: decoder of the two-byte return-from-interrupt opcode
`timescale 1ns/1ps
module dpp_return_from_irq_opcode_dec
	import dpp_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// fetch stream
	dpp_fetch_if.dec  fetch
);
	logic       act_q;  // fetch active last cycle
	logic [7:0] byte_q; // last byte seen while fetching
	logic       ed_q;   // prefix decoded
	logic       return_from_irq_opcode_q; // return pulse
	logic       fetch_end;

	// byte is judged when the fetch strobe goes away
	assign fetch_end = act_q & ~fetch.fetch_act;

	// track fetch and hold its last byte
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			act_q  <= 1'b0;
			byte_q <= 8'h00;
		end
		else
		begin
			act_q <= fetch.fetch_act;
			if (fetch.fetch_act)
				byte_q <= fetch.op_byte;
		end
	end

	// prefix flag and return pulse
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ed_q   <= 1'b0;
			return_from_irq_opcode_q <= 1'b0;
		end
		else
		begin
			return_from_irq_opcode_q <= 1'b0;
			if (fetch_end)
			begin
				// second byte after prefix ends the service
				return_from_irq_opcode_q <= ed_q & (byte_q == DPP_OP_RETURN);
				ed_q   <= ~ed_q & (byte_q == DPP_OP_PREFIX);
			end
		end
	end

	assign fetch.ed_seen = ed_q;
	assign fetch.return_from_irq_opcode    = return_from_irq_opcode_q;
endmodule : dpp_return_from_irq_opcode_dec

// >>> dpp_top.sv
// module: dual 8-bit parallel port with vectored daisy-chain interrupts
// Notes on behaviour
// - first port wins over second port
// - chain out high only with chain in high, no service, no pending except after prefix
// - per-port vector, bit zero forced low
// - acknowledge: highest requester drives its vector
// - new enable waits for machine-cycle strobe
// - service state tracked from fetched opcodes
// - select plus request without read writes
// - select, read, request drive port data
// - port select low first, high second
// - control/data select high means command
// - machine cycle alone resets device
// - byte modes take mode and vector words
// - bit mode needs following direction word
// - bit six picks AND or OR
// - bit five picks active input level
// - bit four means mask word follows
// - short word sets or clears enable only
// - output mode: ready after loading register
// - input mode: ready while register empty
// - bidir drives lines only during strobe
// - second strobe loads first input register
// - bit mode: ready low, strobe ignored, except second port while first is bidir
// - output ready until strobe rise, then interrupt
// - input ready clears on strobe, sets on read
// - prefix raises chain, return clears service
// - bit mode read merges output and input
`timescale 1ns/1ps
module dpp_top
	import dpp_pkg::*;
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// host bus controls
	input  wire logic             chip_enable_n_i,
	input  wire logic             port_select_i,
	input  wire logic             ctrl_select_i,
	input  wire logic             io_request_n_i,
	input  wire logic             read_n_i,
	input  wire logic             machine_cycle_strobe_n_i,
	// host data bus, three signals
	input  wire logic [DPP_W-1:0] host_data_bus_i,
	output logic      [DPP_W-1:0] host_data_bus_o,
	output logic                  host_data_bus_oe_o,
	// interrupt request, open drain
	output logic                  irq_line_o,
	output logic                  irq_line_oe_o,
	// priority daisy chain
	input  wire logic             priority_chain_in_i,
	output logic                  priority_chain_out_o,
	// first peripheral port
	input  wire logic [DPP_W-1:0] first_port_lines_i,
	output logic      [DPP_W-1:0] first_port_lines_o,
	output logic      [DPP_W-1:0] first_port_lines_oe_o,
	input  wire logic             first_port_strobe_n_i,
	output logic                  first_port_ready_o,
	// second peripheral port
	input  wire logic [DPP_W-1:0] second_port_lines_i,
	output logic      [DPP_W-1:0] second_port_lines_o,
	output logic      [DPP_W-1:0] second_port_lines_oe_o,
	input  wire logic             second_port_strobe_n_i,
	output logic                  second_port_ready_o
);
	// read value of a port: bit mode merges by direction
	function automatic logic [7:0] read_val(input logic [1:0] m,
		input logic [7:0] o, input logic [7:0] i, input logic [7:0] d);
		if (m == DPP_MODE_OUT)
			read_val = o;
		else if (m == DPP_MODE_BIT)
			read_val = (o & ~d) | (i & d);
		else
			read_val = i;
	endfunction : read_val

	// reset synchroniser
	logic rst_meta_q;             // first stage, read only by second
	logic rst_sync_q;             // released reset used everywhere

	// sampled host inputs
	logic       ce_n_q;           // chip enable
	logic       psel_q;           // port select
	logic       csel_q;           // control/data select
	logic       io_request_n_n_q;         // io request
	logic       rd_n_q;           // read
	logic       m1_n_q;           // machine-cycle strobe
	logic [7:0] din_q;            // host data in
	logic [1:0] stb_n_q;          // strobes, current sample
	logic [1:0] stb_prev_q;       // strobes, previous sample
	logic [1:0][7:0] lines_q;     // peripheral lines sampled

	// cycle decode
	logic wr_act, rd_act, ack_act, fetch_act, soft_rst;
	logic wr_prev_q, rd_prev_q, ack_prev_q;
	logic wr_pulse, rd_end, ack_start;
	logic rd_port_q;              // port read by current cycle
	logic [1:0] stb_rise;         // strobe rising edges

	// per-port configuration
	logic [1:0][1:0] mode_q;      // operating mode
	logic [1:0][7:0] out_q;       // output register
	logic [1:0][7:0] in_q;        // input register
	logic [1:0][7:0] dir_q;       // 1 = input line
	logic [1:0][7:0] mask_q;      // 1 = masked line
	logic [1:0][7:0] vec_q;       // interrupt vector
	logic [1:0]      ie_q;        // interrupt enable as written
	logic [1:0]      ie_live_q;   // enable armed by machine cycle
	logic [1:0]      and_q;       // AND function selected
	logic [1:0]      high_q;      // active level high
	dpp_cw_state_t   cw_q [2];    // next control word expected

	// handshake and interrupt state
	logic [1:0] rdy_q;            // ready outputs
	logic [1:0] cond_q;           // bit-mode condition last cycle
	logic [1:0] cond;             // bit-mode condition now
	logic [1:0] ev;               // interrupt source events
	logic [1:0] ip_q;             // pending requests
	logic [1:0] ius_q;            // under service
	logic [1:0] ci, co;           // chain in/out per port
	logic [1:0] req;              // requesting with chain open
	logic       own_q;            // this device answers the ack
	logic [7:0] dout_q;           // host data out register
	logic       doe_q;            // host data out enable
	logic       bidir;            // first port in bidir mode

	dpp_fetch_if fetch_if ();     // opcode stream to decoder

	// two-flop reset release
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// sample every host and handshake input on the clock
	always_ff @(posedge clk_i or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			ce_n_q     <= 1'b1;
			psel_q     <= 1'b0;
			csel_q     <= 1'b0;
			io_request_n_n_q   <= 1'b1;
			rd_n_q     <= 1'b1;
			m1_n_q     <= 1'b1;
			din_q      <= 8'h00;
			stb_n_q    <= 2'h3;
			stb_prev_q <= 2'h3;
			lines_q    <= '0;
		end
		else
		begin
			ce_n_q     <= chip_enable_n_i;
			psel_q     <= port_select_i;
			csel_q     <= ctrl_select_i;
			io_request_n_n_q   <= io_request_n_i;
			rd_n_q     <= read_n_i;
			m1_n_q     <= machine_cycle_strobe_n_i;
			din_q      <= host_data_bus_i;
			stb_n_q    <= {second_port_strobe_n_i, first_port_strobe_n_i};
			stb_prev_q <= stb_n_q;
			lines_q    <= {second_port_lines_i, first_port_lines_i};
		end
	end

	// bus cycle decode on sampled strobes
	assign wr_act    = ~ce_n_q & ~io_request_n_n_q & rd_n_q & m1_n_q;
	assign rd_act    = ~ce_n_q & ~io_request_n_n_q & ~rd_n_q;
	assign ack_act   = ~io_request_n_n_q & ~m1_n_q;
	assign fetch_act = ~m1_n_q & ~rd_n_q;
	assign soft_rst  = ~m1_n_q & rd_n_q & io_request_n_n_q;
	assign wr_pulse  = wr_act & ~wr_prev_q;
	assign rd_end    = rd_prev_q & ~rd_act;
	assign ack_start = ack_act & ~ack_prev_q;
	assign stb_rise  = stb_n_q & ~stb_prev_q;
	assign bidir     = (mode_q[0] == DPP_MODE_BIDIR);

	// cycle edge history and port of the read
	always_ff @(posedge clk_i or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			wr_prev_q  <= 1'b0;
			rd_prev_q  <= 1'b0;
			ack_prev_q <= 1'b0;
			rd_port_q  <= 1'b0;
		end
		else
		begin
			wr_prev_q  <= wr_act;
			rd_prev_q  <= rd_act;
			ack_prev_q <= ack_act;
			if (rd_act)
				rd_port_q <= psel_q;
		end
	end

	// control words and output data writes
	always_ff @(posedge clk_i or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			for (int p = 0; p < 2; p++)
			begin
				mode_q[p] <= DPP_MODE_RST;
				out_q[p]  <= DPP_DATA_RST;
				dir_q[p]  <= DPP_DIR_RST;
				mask_q[p] <= DPP_MASK_RST;
				vec_q[p]  <= DPP_VEC_RST;
				cw_q[p]   <= DPP_CW_IDLE;
			end
			ie_q   <= 2'h0;
			and_q  <= 2'h0;
			high_q <= 2'h0;
		end
		else if (soft_rst)
		begin
			// machine cycle alone: mode and mask back to defaults, interrupts off
			for (int p = 0; p < 2; p++)
			begin
				mode_q[p] <= DPP_MODE_RST;
				mask_q[p] <= DPP_MASK_RST;
				cw_q[p]   <= DPP_CW_IDLE;
			end
			ie_q <= 2'h0;
		end
		else if (wr_pulse && !csel_q)
			out_q[psel_q] <= din_q;
		else if (wr_pulse)
		begin
			case (cw_q[psel_q])
				// word after bit-mode selection sets directions
				DPP_CW_DIR:
				begin
					dir_q[psel_q] <= din_q;
					cw_q[psel_q]  <= DPP_CW_IDLE;
				end
				// word after mask flag is the mask
				DPP_CW_MASK:
				begin
					mask_q[psel_q] <= din_q;
					cw_q[psel_q]   <= DPP_CW_IDLE;
				end
				DPP_CW_IDLE:
				begin
					if (din_q[DPP_VEC_BIT] == 1'b0)
						vec_q[psel_q] <= din_q;
					else if (din_q[3:0] == DPP_CW_MODE)
					begin
						// bidir exists on the first port only
						if (psel_q && din_q[DPP_MODE_MSB:DPP_MODE_LSB]
							== DPP_MODE_BIDIR)
							mode_q[1] <= DPP_MODE_OUT;
						else
							mode_q[psel_q] <=
								din_q[DPP_MODE_MSB:DPP_MODE_LSB];
						if (din_q[DPP_MODE_MSB:DPP_MODE_LSB] == DPP_MODE_BIT)
							cw_q[psel_q] <= DPP_CW_DIR;
					end
					else if (din_q[3:0] == DPP_CW_ICW)
					begin
						ie_q[psel_q]   <= din_q[DPP_ICW_IE];
						and_q[psel_q]  <= din_q[DPP_ICW_AND];
						high_q[psel_q] <= din_q[DPP_ICW_HIGH];
						if (din_q[DPP_ICW_MASKF])
							cw_q[psel_q] <= DPP_CW_MASK;
					end
					else if (din_q[3:0] == DPP_CW_IEN)
						ie_q[psel_q] <= din_q[DPP_ICW_IE];
				end
				default:
					cw_q[psel_q] <= DPP_CW_IDLE;
			endcase
		end
	end

	// enable becomes live only at the next machine-cycle strobe
	always_ff @(posedge clk_i or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			ie_live_q <= 2'h0;
		else
			for (int p = 0; p < 2; p++)
				if (!ie_q[p])
					ie_live_q[p] <= 1'b0;
				else if (!m1_n_q)
					ie_live_q[p] <= 1'b1;
	end

	// input registers
	always_ff @(posedge clk_i or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			in_q <= '0;
		else
		begin
			for (int p = 0; p < 2; p++)
				if (mode_q[p] == DPP_MODE_IN && !stb_n_q[p])
					in_q[p] <= lines_q[p];
				else if (mode_q[p] == DPP_MODE_BIT && !rd_act)
					in_q[p] <= lines_q[p]; // held from read start
			if (bidir && !stb_n_q[1])
				in_q[0] <= lines_q[0];
		end
	end

	// ready handshake per port
	always_ff @(posedge clk_i or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			rdy_q <= 2'h0;
		else if (soft_rst)
			rdy_q <= 2'h0;
		else
			for (int p = 0; p < 2; p++)
			begin
				if (p == 1 && bidir)
				begin
					// second handshake serves first input register
					if (rd_end && !rd_port_q)
						rdy_q[1] <= 1'b1;
					else if (stb_rise[1])
						rdy_q[1] <= 1'b0;
				end
				else
					case (mode_q[p])
						DPP_MODE_OUT, DPP_MODE_BIDIR:
							// write sets, strobe rise clears; set wins
							if (wr_pulse && !csel_q && psel_q == p[0])
								rdy_q[p] <= 1'b1;
							else if (stb_rise[p])
								rdy_q[p] <= 1'b0;
						DPP_MODE_IN:
							if (rd_end && rd_port_q == p[0])
								rdy_q[p] <= 1'b1;
							else if (stb_rise[p])
								rdy_q[p] <= 1'b0;
						default:
							rdy_q[p] <= 1'b0;
					endcase
			end
	end

	// bit-mode match: AND of all unmasked or OR of any
	always_comb
	begin
		for (int p = 0; p < 2; p++)
		begin
			logic [7:0] hit;
			hit = (high_q[p] ? lines_q[p] : ~lines_q[p]) & dir_q[p];
			if (and_q[p])
				cond[p] = &(hit | mask_q[p] | ~dir_q[p])
					& |(~mask_q[p] & dir_q[p]);
			else
				cond[p] = |(hit & ~mask_q[p]);
			// handshake modes interrupt on the strobe rising edge
			if (mode_q[p] == DPP_MODE_BIT)
				ev[p] = cond[p] & ~cond_q[p] & ~(p == 1 && bidir);
			else
				ev[p] = stb_rise[p];
		end
	end

	// daisy chain: first port sits ahead of the second
	assign ci[0] = priority_chain_in_i;
	assign ci[1] = co[0];
	assign co    = ci & ~ius_q & ~(ip_q & {2{~fetch_if.ed_seen}});
	assign req   = ip_q & ci & ~ius_q;
	assign priority_chain_out_o = co[1];

	// pending and under-service state
	always_ff @(posedge clk_i or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			ip_q   <= 2'h0;
			ius_q  <= 2'h0;
			cond_q <= 2'h0;
			own_q  <= 1'b0;
		end
		else if (soft_rst)
		begin
			ip_q  <= 2'h0;
			ius_q <= 2'h0;
		end
		else
		begin
			cond_q <= cond;
			if (ack_start)
				own_q <= |req;
			for (int p = 0; p < 2; p++)
			begin
				// ack goes to the first requester in chain order
				if (ack_start && req[p] && (p == 0 || !req[0]))
				begin
					ip_q[p]  <= 1'b0;
					ius_q[p] <= 1'b1;
				end
				else if (!ie_live_q[p])
					ip_q[p] <= 1'b0;
				// an event in the ack cycle stays pending; set wins
				if (ev[p] && ie_live_q[p])
					ip_q[p] <= 1'b1;
				// return clears only the port whose chain is open
				if (fetch_if.return_from_irq_opcode && ci[p] && ius_q[p])
					ius_q[p] <= 1'b0;
			end
		end
	end

	// host data out: port read or vector during acknowledge
	always_ff @(posedge clk_i or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			dout_q <= 8'h00;
			doe_q  <= 1'b0;
		end
		else if (rd_act)
		begin
			dout_q <= read_val(mode_q[psel_q], out_q[psel_q],
				in_q[psel_q], dir_q[psel_q]);
			doe_q  <= 1'b1;
		end
		else if (ack_start)
		begin
			dout_q <= req[0] ? vec_q[0] : vec_q[1];
			doe_q  <= |req;
		end
		else
			doe_q <= ack_act & own_q;
	end

	// opcode stream decoder
	assign fetch_if.fetch_act = fetch_act;
	assign fetch_if.op_byte   = din_q;

	dpp_return_from_irq_opcode_dec u_return_from_irq_opcode (
		.clk_i   (clk_i),
		.rst_n_i (rst_sync_q),
		.fetch   (fetch_if.dec)
	);

	// host side outputs
	assign host_data_bus_o    = {dout_q[7:1], 1'b0 & dout_q[0]}
		| (doe_q & ~ack_act ? {7'h00, dout_q[0]} : 8'h00);
	assign host_data_bus_oe_o = doe_q;
	assign irq_line_o         = 1'b0;
	assign irq_line_oe_o      = |req;

	// peripheral side outputs
	assign first_port_lines_o     = out_q[0];
	assign second_port_lines_o    = out_q[1];
	assign first_port_lines_oe_o  =
		bidir ? {8{~stb_n_q[0]}} :
		(mode_q[0] == DPP_MODE_OUT) ? 8'hFF :
		(mode_q[0] == DPP_MODE_BIT) ? ~dir_q[0] : 8'h00;
	assign second_port_lines_oe_o =
		(mode_q[1] == DPP_MODE_OUT) ? 8'hFF :
		(mode_q[1] == DPP_MODE_BIT) ? ~dir_q[1] : 8'h00;
	assign first_port_ready_o     = rdy_q[0];
	assign second_port_ready_o    = rdy_q[1];
endmodule : dpp_top

// >>> dpp_top_props.sv
// checker: port-level properties of the dual parallel port
`timescale 1ns/1ps
module dpp_top_props
(
	// clock, reset and host bus
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       chip_enable_n_i,
	input wire logic       io_request_n_i,
	input wire logic       read_n_i,
	input wire logic       machine_cycle_strobe_n_i,
	input wire logic [7:0] host_data_bus_o,
	input wire logic       host_data_bus_oe_o,
	// interrupt and chain
	input wire logic       irq_line_oe_o,
	input wire logic       priority_chain_in_i,
	input wire logic       priority_chain_out_o,
	// handshake ports
	input wire logic [7:0] first_port_lines_oe_o,
	input wire logic       first_port_strobe_n_i,
	input wire logic       first_port_ready_o,
	input wire logic       second_port_strobe_n_i,
	input wire logic       second_port_ready_o
);
	logic rd_c;  // host read cycle
	logic wr_c;  // host write cycle
	logic ack_c; // interrupt acknowledge
	logic sr_c;  // machine cycle alone
	assign rd_c  = !chip_enable_n_i && !io_request_n_i && !read_n_i
		&& machine_cycle_strobe_n_i;
	assign wr_c  = !chip_enable_n_i && !io_request_n_i && read_n_i
		&& machine_cycle_strobe_n_i;
	assign ack_c = !io_request_n_i && !machine_cycle_strobe_n_i && read_n_i;
	assign sr_c  = !machine_cycle_strobe_n_i && read_n_i && io_request_n_i;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	AST_CHAIN_GATE: assert property (
		priority_chain_out_o |-> priority_chain_in_i)
		else $error("chain out high with chain in low");
	AST_VEC_LSB: assert property (
		ack_c && $past(ack_c) && host_data_bus_oe_o |-> !host_data_bus_o[0])
		else $error("vector bit zero set");
	AST_ACK_BLOCK: assert property (
		(ack_c && !priority_chain_in_i) [*3] |-> !host_data_bus_oe_o)
		else $error("vector driven with chain in low");
	AST_RD_OE: assert property (
		rd_c [*3] |-> host_data_bus_oe_o)
		else $error("read not answered");
	AST_OE_DROP: assert property (
		io_request_n_i [*3] |-> !host_data_bus_oe_o)
		else $error("host bus driven without request");
	AST_WR_QUIET: assert property (
		wr_c [*3] |-> !host_data_bus_oe_o)
		else $error("host bus driven during write");
	AST_OE_CAUSE: assert property (
		$rose(host_data_bus_oe_o) |-> $past(rd_c) || $past(ack_c))
		else $error("bus drive before sampled request");
	AST_RDY1_CLR: assert property (
		$rose(first_port_strobe_n_i) |-> ##[1:4] !first_port_ready_o)
		else $error("first ready kept after strobe");
	AST_RDY2_CLR: assert property (
		$rose(second_port_strobe_n_i) |-> ##[1:4] !second_port_ready_o)
		else $error("second ready kept after strobe");
	AST_SOFT_RST: assert property (
		sr_c [*4] |-> !first_port_ready_o && !second_port_ready_o
			&& !irq_line_oe_o && first_port_lines_oe_o == 8'h00)
		else $error("machine cycle alone did not reset");
	// main scenarios reached
	cover property (ack_c && host_data_bus_oe_o);
	cover property (rd_c && host_data_bus_oe_o);
	cover property ($fell(first_port_ready_o));
	cover property (irq_line_oe_o);
endmodule : dpp_top_props
bind dpp_top dpp_top_props u_props (.clk_i, .rst_n_i, .chip_enable_n_i,
	.io_request_n_i, .read_n_i, .machine_cycle_strobe_n_i, .host_data_bus_o,
	.host_data_bus_oe_o, .irq_line_oe_o, .priority_chain_in_i,
	.priority_chain_out_o, .first_port_lines_oe_o, .first_port_strobe_n_i,
	.first_port_ready_o, .second_port_strobe_n_i, .second_port_ready_o);

// >>> dpp_periph_model.sv
// model: peripheral devices on the two handshake ports
`timescale 1ns/1ps
module dpp_periph_model
(
	// clock
	input  wire logic       clk_i,
	// line drive from the device
	input  wire logic [7:0] a_o_i,
	input  wire logic [7:0] a_oe_i,
	input  wire logic [7:0] b_o_i,
	input  wire logic [7:0] b_oe_i,
	// wire levels and strobes towards the device
	output logic      [7:0] a_lvl_o,
	output logic      [7:0] b_lvl_o,
	output logic            a_stb_n_o,
	output logic            b_stb_n_o
);
	logic [7:0] v_q [2] = '{8'h00, 8'h00}; // last driven values
	logic       d_q [2] = '{1'b0, 1'b0};   // model drives lines
	// released lines show the inverse of the last value
	assign a_lvl_o = (a_oe_i & a_o_i) | (~a_oe_i & (d_q[0] ? v_q[0] : ~v_q[0]));
	assign b_lvl_o = (b_oe_i & b_o_i) | (~b_oe_i & (d_q[1] ? v_q[1] : ~v_q[1]));
	initial
	begin
		a_stb_n_o = 1'b1;
		b_stb_n_o = 1'b1;
	end
	// static drive of one port's lines
	task automatic drive(input logic p, input logic [7:0] v);
		v_q[p] = v;
		d_q[p] = 1'b1;
	endtask : drive
	// strobe pulse; data held across the whole low phase
	task automatic pulse(input logic sp, input logic lp, input logic drv,
		input logic [7:0] v, input int len);
		if (drv)
			drive(lp, v);
		@(posedge clk_i);
		#10;
		{a_stb_n_o, b_stb_n_o} = sp ? 2'b10 : 2'b01;
		repeat (len) @(posedge clk_i);
		#10;
		{a_stb_n_o, b_stb_n_o} = 2'b11;
		@(posedge clk_i);
		#10;
		d_q[lp] = 1'b0;
		repeat (2) @(posedge clk_i);
		#10;
	endtask : pulse
endmodule : dpp_periph_model

// >>> dpp_top_tb.sv
// testbench: host bus and handshake scenarios for the parallel port
`timescale 1ns/1ps
module dpp_top_tb;
	import dpp_pkg::*;
	logic       clk_i = 0, rst_n_i = 0;          // clock and reset
	logic       ce_n = 1, io_request_n_n = 1, rd_n = 1, m1_n = 1; // bus strobes
	logic       psel = 0, csel = 0, chain_in = 1; // selects and chain
	logic [7:0] hd_i = 8'h00, bus_q;             // host data
	wire  [7:0] hd_w, hd_o, a_o, a_oe, b_o, b_oe, a_lvl, b_lvl;
	wire        hd_oe, irq_oe, chain_out, a_stb, b_stb, a_rdy, b_rdy;
	wire        irq_o;                           // interrupt pin level
	int         fail_count = 0, cmp_count = 0;
	// host bus level: device wins while it drives
	assign hd_w = hd_oe ? hd_o : hd_i;
	dpp_top dut (.clk_i, .rst_n_i, .chip_enable_n_i(ce_n),
		.port_select_i(psel), .ctrl_select_i(csel), .io_request_n_i(io_request_n_n),
		.read_n_i(rd_n), .machine_cycle_strobe_n_i(m1_n),
		.host_data_bus_i(hd_w), .host_data_bus_o(hd_o),
		.host_data_bus_oe_o(hd_oe), .irq_line_o(irq_o), .irq_line_oe_o(irq_oe),
		.priority_chain_in_i(chain_in), .priority_chain_out_o(chain_out),
		.first_port_lines_i(a_lvl), .first_port_lines_o(a_o),
		.first_port_lines_oe_o(a_oe), .first_port_strobe_n_i(a_stb),
		.first_port_ready_o(a_rdy), .second_port_lines_i(b_lvl),
		.second_port_lines_o(b_o), .second_port_lines_oe_o(b_oe),
		.second_port_strobe_n_i(b_stb), .second_port_ready_o(b_rdy));
	dpp_periph_model pm (.clk_i, .a_o_i(a_o), .a_oe_i(a_oe), .b_o_i(b_o),
		.b_oe_i(b_oe), .a_lvl_o(a_lvl), .b_lvl_o(b_lvl), .a_stb_n_o(a_stb),
		.b_stb_n_o(b_stb));
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	// flags: pin level, ready a, ready b, interrupt, chain out
	function automatic logic [7:0] fl();
		return {3'h0, irq_o, a_rdy, b_rdy, irq_oe, chain_out};
	endfunction : fl
	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// one bus cycle {ce,io_request_n,rd,m1} held n edges, then idle
	task automatic bus(input logic [3:0] c, input logic p, input logic k,
		input logic [7:0] d, input int n);
		@(posedge clk_i);
		#10;
		{ce_n, io_request_n_n, rd_n, m1_n} = c;
		{psel, csel, hd_i} = {p, k, d};
		repeat (n) @(posedge clk_i);
		#10;
		bus_q = hd_w;
		{ce_n, io_request_n_n, rd_n, m1_n} = 4'hF;
		// let ready and service updates after the cycle settle
		repeat (3) @(posedge clk_i);
		#10;
	endtask : bus
	task automatic wr(input logic p, input logic k, input logic [7:0] d);
		bus(4'h3, p, k, d, 3);
	endtask : wr
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// watchdog, well past the expected run length
	initial
	begin
		#200000;
		fail_count++;
		tally_and_finish;
	end
	initial
	begin
		repeat (3) @(posedge clk_i);
		#10 rst_n_i = 1;
		repeat (4) @(posedge clk_i);
		#10;
		chk("flags", fl(), 8'h01);
		chk("a oe", a_oe, 8'h00);
		$display("test reset done");
		// both ports output mode, vectors, interrupts on
		wr(0, 1, 8'h0F);
		wr(0, 1, 8'h20);
		wr(0, 1, 8'h87);
		wr(1, 1, 8'h0F);
		wr(1, 1, 8'h40);
		wr(1, 1, 8'h87);
		wr(0, 0, 8'hA5);
		wr(1, 0, 8'h3C);
		chk("a lines", a_o, 8'hA5);
		chk("a oe", a_oe, 8'hFF);
		chk("b oe", b_oe, 8'hFF);
		chk("b lines", b_o, 8'h3C);
		chk("flags", fl(), 8'h0D);
		pm.pulse(0, 0, 0, 8'h00, 1);
		chk("flags", fl(), 8'h05);
		bus(4'hC, 0, 0, 8'h00, 2);
		wr(0, 0, 8'h5A);
		pm.pulse(0, 0, 0, 8'h00, 4);
		pm.pulse(1, 1, 0, 8'h00, 1);
		chk("flags", fl(), 8'h02);
		chain_in = 0;
		bus(4'hA, 0, 0, 8'hFF, 3);
		chk("blocked ack", bus_q, 8'hFF);
		chain_in = 1;
		bus(4'hA, 0, 0, 8'hFF, 3);
		chk("vector a", bus_q, 8'h20);
		chk("chain", fl() & 8'h01, 8'h00);
		bus(4'hC, 0, 0, 8'hED, 2);
		bus(4'hC, 0, 0, 8'h4D, 2);
		bus(4'hA, 0, 0, 8'hFF, 3);
		chk("vector b", bus_q, 8'h40);
		bus(4'hC, 0, 0, 8'hED, 2);
		bus(4'hC, 0, 0, 8'h4D, 2);
		chk("flags", fl() & 8'h03, 8'h01);
		$display("test output and interrupts done");
		// second port input mode, interrupt disabled
		wr(1, 1, 8'h03);
		wr(1, 1, 8'h4F);
		bus(4'h1, 1, 0, 8'h00, 3);
		chk("b ready", fl() & 8'h04, 8'h04);
		pm.pulse(1, 1, 1, 8'hC3, 2);
		chk("flags", fl() & 8'h06, 8'h00);
		bus(4'h1, 1, 0, 8'h00, 3);
		chk("b data", bus_q, 8'hC3);
		chk("b ready", fl() & 8'h04, 8'h04);
		$display("test input done");
		// first port bit mode, low nibble inputs
		wr(0, 1, 8'hCF);
		wr(0, 1, 8'h0F);
		wr(0, 0, 8'hA0);
		pm.drive(0, 8'h05);
		chk("a oe", a_oe, 8'hF0);
		bus(4'h1, 0, 0, 8'h00, 3);
		chk("a bits", bus_q, 8'hA5);
		// AND, active high: bit one low keeps the match off
		wr(0, 1, 8'hF7);
		wr(0, 1, 8'hFC);
		chk("and miss", fl() & 8'h02, 8'h00);
		wr(0, 1, 8'hF7);
		wr(0, 1, 8'hFA);
		chk("and hit", fl() & 8'h02, 8'h02);
		pm.pulse(0, 0, 1, 8'h05, 1);
		chk("a ready", fl() & 8'h08, 8'h00);
		$display("test bit mode done");
		// bidirectional first port, second port in bit mode
		wr(1, 1, 8'hCF);
		wr(1, 1, 8'hFF);
		wr(0, 1, 8'h8F);
		wr(0, 0, 8'h5A);
		chk("a oe idle", a_oe, 8'h00);
		fork
			pm.pulse(0, 0, 0, 8'h00, 4);
			begin
				repeat (4) @(posedge clk_i);
				#10;
				chk("a oe strobe", a_oe, 8'hFF);
				chk("a lines", a_o, 8'h5A);
			end
		join
		pm.pulse(1, 0, 1, 8'h69, 2);
		bus(4'h1, 0, 0, 8'h00, 3);
		chk("a input", bus_q, 8'h69);
		chk("b ready", fl() & 8'h04, 8'h04);
		$display("test bidirectional done");
		// machine cycle alone resets
		bus(4'hE, 0, 0, 8'h00, 4);
		chk("a oe", a_oe, 8'h00);
		chk("flags", fl(), 8'h01);
		$display("test soft reset done");
		tally_and_finish;
	end
endmodule : dpp_top_tb
